// *** core/lpbp_hold.sv ***
// holding registers for partner mid and high words
// assumes capture is a one-cycle pulse in the CORE_CLK domain
`timescale 1ns/10ps
`default_nettype none
module lpbp_hold (
  input wire logic clk, // core clock
  input wire logic rst, // synchronous reset, active high
  lpbp_hold_if.hold hif // capture request and held words
);
  import lpbp_pkg::*;

  // snapshot both upper words together so a multi-word read is coherent
  always_ff @(posedge clk) begin
    if (rst) begin
      hif.held_mid <= LPBP_MID_RST; // RULE4
      hif.held_high <= LPBP_HIGH_RST;
    end else if (hif.capture) begin
      hif.held_mid <= hif.live_mid & LPBP_MID_MASK; // RULE1
      hif.held_high <= hif.live_high & LPBP_HIGH_MASK; // RULE1
    end
  end
endmodule : lpbp_hold
`default_nettype wire

// *** core/lpbp_hold_if.sv ***
// carrier between the top and the holding register module
// assumes single clock domain
`timescale 1ns/10ps
`default_nettype none
interface lpbp_hold_if;
  import lpbp_pkg::*;
  logic capture;
  logic [15:0] live_mid;
  logic [15:0] live_high;
  logic [15:0] held_mid;
  logic [15:0] held_high;
  modport top (output capture, output live_mid, output live_high, input held_mid, input held_high);
  modport hold (input capture, input live_mid, input live_high, output held_mid, output held_high);
endinterface : lpbp_hold_if
`default_nettype wire

// *** core/lpbp_pkg.sv ***
// package for the partner base page ability register slice
// assumes a 16-bit management register port with word addresses
package lpbp_pkg;
  localparam int unsigned LPBP_ADDR_W = 16;
  localparam int unsigned LPBP_DATA_W = 16;
  // register addresses
  localparam logic [15:0] LPBP_LOW_ADDR = 16'h0205;
  localparam logic [15:0] LPBP_MID_ADDR = 16'h0206;
  localparam logic [15:0] LPBP_HIGH_ADDR = 16'h0207;
  // reset values
  localparam logic [15:0] LPBP_LOW_RST = 16'h0000;
  localparam logic [15:0] LPBP_MID_RST = 16'h0000;
  localparam logic [15:0] LPBP_HIGH_RST = 16'h0000;
  // low word field positions
  localparam int unsigned LPBP_NP_REQ_BIT = 15;
  localparam int unsigned LPBP_ACK_BIT = 14;
  localparam int unsigned LPBP_RFAULT_BIT = 13;
  localparam int unsigned LPBP_FORCE_BIT = 12;
  localparam int unsigned LPBP_PAUSE_MSB = 11;
  localparam int unsigned LPBP_PAUSE_LSB = 10;
  localparam int unsigned LPBP_SEL_MSB = 4;
  localparam int unsigned LPBP_SEL_LSB = 0;
  localparam logic [4:0] LPBP_SEL_STD = 5'h01;
  // mid word field positions
  localparam int unsigned LPBP_B10L_BIT = 14;
  localparam int unsigned LPBP_B1000_BIT = 7;
  localparam int unsigned LPBP_B10SFD_BIT = 6;
  localparam int unsigned LPBP_B100_BIT = 5;
  localparam int unsigned LPBP_ROLE_BIT = 4;
  // implemented bits; everything else reads zero
  localparam logic [15:0] LPBP_LOW_MASK = 16'hfc1f;
  localparam logic [15:0] LPBP_MID_MASK = 16'h40f0;
  localparam logic [15:0] LPBP_HIGH_MASK = 16'h7800;
endpackage : lpbp_pkg

// *** core/lpbp_regs.sv ***
// partner base page ability register slice, low, mid and high words
// assumes receive logic presents a stable live codeword
// Overview of operation
// RULE1: reading the low word snapshots the mid and high words
// RULE2: mid word reads return the snapshot, not the live value
// RULE3: high word reads return the snapshot, not the live value
// RULE4: all three partner ability registers reset to zero; only mid and high are held, a low read after reset returns the live page
// RULE5: low bit 15 shows partner next page request
// RULE6: low bit 14 shows partner acknowledge
// RULE7: low bit 13 shows partner remote fault
// RULE8: low bit 12 shows partner forced role flag
// RULE9: low bits 11:10 show partner pause support
// RULE10: low bits 4:0 show partner selector, normally 00001
// RULE11: mid bit 14 shows partner 10BASE-T1L ability
// RULE12: mid bit 7 shows partner 1000BASE-T1 ability
// RULE13: mid bit 6 shows partner 10BASE-T1S full duplex ability
// RULE14: mid bit 5 shows partner 100BASE-T1 ability
// RULE15: mid bit 4 shows partner role, 1 leader 0 follower
// RULE16: writes are ignored, reserved bits read zero
`timescale 1ns/10ps
`default_nettype none
module lpbp_regs (
  input wire logic CORE_CLK, // 200 MHz core clock
  input wire logic RST, // synchronous reset, active high
  input wire logic REG_RD, // register read strobe, one cycle
  input wire logic REG_WR, // register write strobe, ignored
  input wire logic [lpbp_pkg::LPBP_ADDR_W-1:0] REG_ADDR, // register address
  input wire logic [lpbp_pkg::LPBP_DATA_W-1:0] REG_WDATA, // write data, ignored
  output logic [lpbp_pkg::LPBP_DATA_W-1:0] REG_RDATA, // read data, registered
  output logic REG_RVALID, // read data valid, one cycle
  input wire logic PAGE_VALID, // received base page valid, level
  input wire logic PAGE_NP_REQ, // partner next page request
  input wire logic PAGE_ACK, // partner acknowledge
  input wire logic PAGE_RFAULT, // partner remote fault
  input wire logic PAGE_FORCE, // partner forced role flag
  input wire logic [1:0] PAGE_PAUSE, // partner pause field
  input wire logic [4:0] PAGE_SEL, // partner selector field
  input wire logic PAGE_B10L, // partner 10BASE-T1L ability
  input wire logic PAGE_B1000, // partner 1000BASE-T1 ability
  input wire logic PAGE_B10SFD, // partner 10BASE-T1S full duplex
  input wire logic PAGE_B100, // partner 100BASE-T1 ability
  input wire logic PAGE_ROLE, // partner role bit, 1 leader
  input wire logic [15:0] PAGE_HIGH // partner high word, bits 47:32
);
  import lpbp_pkg::*;

  logic [15:0] live_low;
  logic [15:0] live_mid;
  logic [15:0] nxt_rdata;
  logic [15:0] rdata_ff;
  logic rvalid_ff;
  logic unused_wr;

  lpbp_hold_if hif ();

  // live low word assembly from the received page
  always_comb begin
    live_low = 16'h0000;
    if (PAGE_VALID) begin
      live_low[LPBP_NP_REQ_BIT] = PAGE_NP_REQ; // RULE5
      live_low[LPBP_ACK_BIT] = PAGE_ACK; // RULE6
      live_low[LPBP_RFAULT_BIT] = PAGE_RFAULT; // RULE7
      live_low[LPBP_FORCE_BIT] = PAGE_FORCE; // RULE8
      live_low[LPBP_PAUSE_MSB:LPBP_PAUSE_LSB] = PAGE_PAUSE; // RULE9
      live_low[LPBP_SEL_MSB:LPBP_SEL_LSB] = PAGE_SEL; // RULE10
    end
  end

  // live mid word assembly; no page received means all zero
  always_comb begin
    live_mid = 16'h0000;
    if (PAGE_VALID) begin
      live_mid[LPBP_B10L_BIT] = PAGE_B10L; // RULE11
      live_mid[LPBP_B1000_BIT] = PAGE_B1000; // RULE12
      live_mid[LPBP_B10SFD_BIT] = PAGE_B10SFD; // RULE13
      live_mid[LPBP_B100_BIT] = PAGE_B100; // RULE14
      live_mid[LPBP_ROLE_BIT] = PAGE_ROLE; // RULE15
    end
  end

  // capture on a low word read, same edge as that read's data latch
  assign hif.capture = REG_RD && (REG_ADDR == LPBP_LOW_ADDR); // RULE1
  assign hif.live_mid = live_mid;
  assign hif.live_high = PAGE_VALID ? PAGE_HIGH : LPBP_HIGH_RST;

  lpbp_hold u_hold (
    .clk (CORE_CLK),
    .rst (RST),
    .hif (hif)
  );

  // read mux; mid and high come from the snapshot taken before this read
  always_comb begin
    case (REG_ADDR)
      LPBP_LOW_ADDR: nxt_rdata = live_low & LPBP_LOW_MASK; // RULE16
      LPBP_MID_ADDR: nxt_rdata = hif.held_mid; // RULE2
      LPBP_HIGH_ADDR: nxt_rdata = hif.held_high; // RULE3
      default: nxt_rdata = 16'h0000;
    endcase
  end

  // registered read data; writes have no path into any state
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      rdata_ff <= LPBP_LOW_RST; // RULE4
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= REG_RD;
      if (REG_RD) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  // write strobe and data are accepted and discarded
  assign unused_wr = REG_WR ^ (^REG_WDATA); // RULE16
  assign REG_RDATA = rdata_ff;
  assign REG_RVALID = rvalid_ff;
endmodule : lpbp_regs
`default_nettype wire

// *** verification/lpbp_host.sv ***
// host model issuing single register accesses
// assumes the answer comes one cycle after the strobe
`timescale 1ns/10ps
`default_nettype none
module lpbp_host (
  input wire logic clk, // core clock
  input wire logic rvalid, // answer valid
  output logic rd = 1'b0, // read strobe
  output logic wr = 1'b0, // write strobe
  output logic [15:0] addr = 16'h0000 // address
);
  // idle address inverted so a stale value never looks selected
  task xfer(input logic [15:0] a, input logic w, output logic ok);
    @(posedge clk);
    {rd, wr, addr} <= {1'b1, w, a};
    @(posedge clk);
    {rd, wr, addr} <= {2'b00, ~a};
    #1 ok = rvalid;
  endtask : xfer
endmodule : lpbp_host
`default_nettype wire

// *** verification/lpbp_regs_checker.sv ***
// assertions on the partner ability register port
// assumes it is bound into lpbp_regs
`timescale 1ns/10ps
`default_nettype none
module lpbp_regs_checker
  import lpbp_pkg::*;
(
  input wire logic CORE_CLK, // clock
  input wire logic RST, // reset
  input wire logic REG_RD, // read
  input wire logic [15:0] REG_ADDR, // address
  input wire logic [15:0] REG_RDATA, // data
  input wire logic REG_RVALID, // valid
  input wire logic PAGE_VALID, // page valid
  input wire logic [4:0] PAGE_SEL // selector
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  logic lo;
  assign lo = REG_RD && REG_ADDR == LPBP_LOW_ADDR;
  // answer one cycle after each read and never otherwise
  rd_answer_a: assert property (REG_RD |=> REG_RVALID) else $error("no answer");
  no_extra_a: assert property (!REG_RD |=> !REG_RVALID) else $error("extra answer");
  data_hold_a: assert property (!REG_RVALID |-> $stable(REG_RDATA)) else $error("data moved");
  reset_zero_a: assert property (disable iff (1'b0) $fell(RST) |-> REG_RDATA == 16'h0000 && !REG_RVALID)
    else $error("reset");
  sel_pass_a: assert property (lo && PAGE_VALID |=> REG_RDATA[4:0] == $past(PAGE_SEL)) else $error("sel");
  low_rsvd_a: assert property (lo |=> REG_RDATA[9:5] == 5'h00) else $error("low rsvd");
  no_page_a: assert property (lo && !PAGE_VALID |=> REG_RDATA == 16'h0000) else $error("no page");
  unmapped_a: assert property (REG_RD && REG_ADDR > LPBP_HIGH_ADDR |=> REG_RDATA == 16'h0000) else $error("unmapped");
  cover property (lo && PAGE_VALID);
  cover property (REG_RD && REG_ADDR == LPBP_MID_ADDR);
  cover property (REG_RD && REG_ADDR > LPBP_HIGH_ADDR);
endmodule : lpbp_regs_checker
bind lpbp_regs lpbp_regs_checker i_lpbp_regs_checker (.*);
`default_nettype wire

// *** verification/lpbp_regs_test.sv ***
// self-checking bench for the partner ability register slice
// assumes the host model drives the register port
`timescale 1ns/10ps
`default_nettype none
module lpbp_regs_test;
  import lpbp_pkg::*;
  logic clk = 1'b0, rst = 1'b1, pv = 1'b0, rd, wr, rv, ok;
  logic [15:0] lw = '0, mw = '0, hw = '0, ad, rdat;
  int n_errors = 0, n_tests = 0;
  // valid, live low, live mid, live high; reserved bits set on purpose
  logic [48:0] rows [3] = '{{1'b1, 16'hffff, 16'hffff, 16'hffff}, {1'b1, 16'ha7e1, 16'h4050, 16'h5000},
    {1'b0, 16'h5402, 16'hbfaf, 16'h2800}};
  always #2.5 clk = ~clk;
  lpbp_host i_lpbp_host (.clk(clk), .rvalid(rv), .rd(rd), .wr(wr), .addr(ad));
  lpbp_regs i_lpbp_regs (.CORE_CLK(clk), .RST(rst), .REG_RD(rd), .REG_WR(wr), .REG_ADDR(ad), .REG_WDATA(16'hffff),
    .REG_RDATA(rdat), .REG_RVALID(rv), .PAGE_VALID(pv), .PAGE_NP_REQ(lw[15]), .PAGE_ACK(lw[14]), .PAGE_RFAULT(lw[13]),
    .PAGE_FORCE(lw[12]), .PAGE_PAUSE(lw[11:10]), .PAGE_SEL(lw[4:0]), .PAGE_B10L(mw[14]), .PAGE_B1000(mw[7]),
    .PAGE_B10SFD(mw[6]), .PAGE_B100(mw[5]), .PAGE_ROLE(mw[4]), .PAGE_HIGH(hw));
  task chk(input logic [15:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // one access; the answer must come and carry the expected word
  task acc(input logic [15:0] a, exp, input logic w = 1'b0);
    i_lpbp_host.xfer(a, w, ok);
    chk({15'h0000, ok}, 16'h0001);
    chk(rdat, exp);
  endtask : acc
  task tally_and_finish;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1 chk(rdat | {15'h0000, rv}, 16'h0000);
    acc(LPBP_MID_ADDR, 16'h0000);
    // live mid and high words flip after each low read; their reads must keep the snapshot
    foreach (rows[i]) begin
      @(posedge clk);
      {pv, lw, mw, hw} <= rows[i];
      acc(LPBP_LOW_ADDR, rows[i][48] ? rows[i][47:32] & LPBP_LOW_MASK : 16'h0000);
      @(posedge clk);
      {mw, hw} <= ~{mw, hw};
      acc(LPBP_MID_ADDR, rows[i][48] ? rows[i][31:16] & LPBP_MID_MASK : 16'h0000);
      acc(LPBP_HIGH_ADDR, rows[i][48] ? rows[i][15:0] & LPBP_HIGH_MASK : 16'h0000, 1'b1);
    end
    acc(LPBP_HIGH_ADDR, 16'h0000);
    acc(16'h0208, 16'h0000);
    @(posedge clk);
    {pv, lw, mw, hw} <= rows[0];
    acc(LPBP_LOW_ADDR, LPBP_LOW_MASK);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    acc(LPBP_MID_ADDR, 16'h0000);
    tally_and_finish();
  end
endmodule : lpbp_regs_test
`default_nettype wire
